// ===== src/sfc_ctrl.v
// sfc_ctrl.v: host controller for a serial NOR flash, top level.
// assumes an AHB-Lite master and a flash on csB, sck and io[3:0].
`include "sfc_regs.vh"
module sfc_ctrl #(
    parameter [7:0] HALF = 8'h04  // mclk cycles per sck half, >= 3
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    output wire        sck,
    output wire        csB,
    output wire [3:0]  ioOut,
    output wire [3:0]  ioOeB,
    input  wire [3:0]  ioIn
);
    localparam [2:0] P_IDLE = 3'h0;
    localparam [2:0] P_OP   = 3'h1;
    localparam [2:0] P_ADR  = 3'h2;
    localparam [2:0] P_MODE = 3'h3;
    localparam [2:0] P_DUM  = 3'h4;
    localparam [2:0] P_DAT  = 3'h5;
    localparam [2:0] P_END  = 3'h6;
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_PRE  = 2'h1;
    localparam [1:0] S_MAIN = 2'h2;
    localparam [1:0] S_POLL = 2'h3;

    wire        wrEn;
    wire [7:0]  regAddr;
    wire [31:0] wrData;
    reg  [31:0] rdData;
    wire [3:0]  ioS;

    reg  [31:0] cmd_q;
    reg  [23:0] adr_q;
    reg  [8:0]  len_q;
    reg  [15:0] wdat_q;
    reg  [31:0] rdat_q;
    reg  [7:0]  sts_q;
    reg  [1:0]  seq_q;
    reg         start_q;
    reg         go_q;
    reg         done_q;
    reg  [2:0]  p_q;
    reg  [7:0]  div_q;
    reg         sck_q;
    reg         csB_q;
    reg  [3:0]  ioOut_q;
    reg  [3:0]  ioOeB_q;
    reg  [31:0] sh_q;
    reg  [31:0] rx_q;
    reg  [5:0]  clk_q;
    reg  [1:0]  ln_q;
    reg  [8:0]  byte_q;

    sfc_ahb_slv u_slv (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hwdata    (hwdata),
        .rdData    (rdData),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .wrEn      (wrEn),
        .regAddr   (regAddr),
        .wrData    (wrData)
    );

    sfc_sync #(.W(4)) u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (ioIn),
        .dout  (ioS)
    );

    // top lanes of the shift word onto the pins; io2/io3 idle high
    function [3:0] laneOut;
        input [31:0] s;
        input [1:0]  c;
        begin
            case (c)
                2'h0:    laneOut = {2'h3, 1'b0, s[31]};
                2'h1:    laneOut = {2'h3, s[31:30]};
                default: laneOut = s[31:28];
            endcase
        end
    endfunction

    // enables are low while driving; single lane always hears io1
    function [3:0] laneOeB;
        input [1:0] c;
        input       rd;
        begin
            case (c)
                2'h0:    laneOeB = 4'h2;
                2'h1:    laneOeB = rd ? 4'h3 : 4'h0;
                default: laneOeB = rd ? 4'hF : 4'h0;
            endcase
        end
    endfunction

    // command fields
    wire [7:0] cOp   = cmd_q[7:0];
    wire       cQpi  = cmd_q[`SFC_B_QPI];
    wire       cVol  = cmd_q[`SFC_B_VOL];
    wire       isSr1 = (cOp == `SFC_OP_WRSR);
    wire       isSr2 = (cOp == `SFC_OP_WRSR2);
    wire       isSrw = isSr1 | isSr2;
    wire       needPre  = isSrw | cmd_q[`SFC_B_WEL];
    wire       needPoll = isSrw | cmd_q[`SFC_B_POLL];
    wire       busy  = (seq_q != S_IDLE) | start_q;
    wire       tick  = (div_q == 8'h00);

    // data byte count, trimmed to what the device accepts
    reg [8:0] lenC;
    always @* begin
        if (isSr2) begin
            lenC = 9'h001;
        end else if (isSr1) begin
            lenC = (len_q >= 9'h002) ? 9'h002 : 9'h001;
        end else if (len_q == 9'h000) begin
            lenC = 9'h001;
        end else if (len_q > `SFC_LEN_MAX) begin
            lenC = `SFC_LEN_MAX;
        end else begin
            lenC = len_q;
        end
    end

    // frame shape for the current sequencer step
    reg [7:0] fOp;
    reg       fAdr;
    reg       fMode;
    reg [3:0] fDum;
    reg       fWr;
    reg       fDat;
    reg [1:0] fOln;
    reg [1:0] fAln;
    reg [1:0] fDln;
    always @* begin
        fOp   = cOp;
        fAdr  = cmd_q[`SFC_B_ADR];
        fMode = cmd_q[`SFC_B_MODE];
        fDum  = cmd_q[`SFC_B_DUM+3:`SFC_B_DUM];
        fWr   = cmd_q[`SFC_B_WR] | isSrw;
        fDat  = cmd_q[`SFC_B_DAT] | isSrw;
        fOln  = cQpi ? 2'h2 : 2'h0;
        fAln  = cQpi ? 2'h2 : cmd_q[`SFC_B_ALN+1:`SFC_B_ALN];
        fDln  = cQpi ? 2'h2 : cmd_q[`SFC_B_DLN+1:`SFC_B_DLN];
        if (seq_q == S_PRE) begin
            // 50h keeps the latch alone, 06h sets it
            fOp   = cVol ? `SFC_OP_VWREN : `SFC_OP_WREN;
            fAdr  = 1'b0;
            fMode = 1'b0;
            fDum  = 4'h0;
            fDat  = 1'b0;
        end else if (seq_q == S_POLL) begin
            fOp   = `SFC_OP_RDSR1;
            fAdr  = 1'b0;
            fMode = 1'b0;
            fDum  = 4'h0;
            fWr   = 1'b0;
            fDat  = 1'b1;
            fDln  = cQpi ? 2'h2 : 2'h0;
        end
    end

    // next phase, skipping absent ones and, without an address, the mode phase
    wire       lastByte = ((byte_q + 9'h001) == lenC);
    wire       more     = (seq_q == S_POLL) ? rx_q[0] : ~lastByte;
    wire [2:0] aftDum   = fDat ? P_DAT : P_END;
    wire [2:0] aftMode  = (fDum != 4'h0) ? P_DUM : aftDum;
    wire [2:0] aftAdr   = fMode ? P_MODE : aftMode;
    wire [2:0] aftOp    = fAdr ? P_ADR : aftMode;
    reg  [2:0] nxt;
    always @* begin
        case (p_q)
            P_IDLE:  nxt = P_OP;
            P_OP:    nxt = aftOp;
            P_ADR:   nxt = aftAdr;
            P_MODE:  nxt = aftMode;
            P_DUM:   nxt = aftDum;
            P_DAT:   nxt = more ? P_DAT : P_END;
            default: nxt = P_END;
        endcase
    end

    // load values for the phase about to start
    wire [7:0] wByte = ((p_q == P_DAT) && !byte_q[0]) ? wdat_q[15:8] : wdat_q[7:0];
    reg  [1:0]  ldLn;
    reg  [31:0] ldSh;
    reg         ldRd;
    reg  [5:0]  ldClk;
    always @* begin
        ldLn  = fAln;
        ldSh  = 32'h0000_0000;
        ldRd  = 1'b0;
        ldClk = 6'h00;
        case (nxt)
            P_OP: begin
                ldLn  = fOln;
                ldSh  = {fOp, 24'h00_0000};
                ldClk = 6'h08 >> fOln;
            end
            P_ADR: begin
                ldSh  = {adr_q, 8'h00};
                ldClk = 6'h18 >> fAln;
            end
            P_MODE: begin
                ldSh  = {cmd_q[`SFC_B_MBYTE+7:`SFC_B_MBYTE], 24'h00_0000};
                ldClk = 6'h08 >> fAln;
            end
            P_DUM: begin
                ldRd  = 1'b1;
                ldClk = {2'h0, fDum};
            end
            P_DAT: begin
                ldLn  = fDln;
                ldRd  = ~fWr;
                ldSh  = {wByte, 24'h00_0000};
                ldClk = 6'h08 >> fDln;
            end
            default: ldClk = 6'h00;
        endcase
    end

    wire endFall = tick && sck_q && (p_q != P_IDLE) && (p_q != P_END) && (clk_q == 6'h01);
    wire doLoad  = ((p_q == P_IDLE) && go_q) || (endFall && (nxt != P_END));
    wire [31:0] shNx = sh_q << (3'h1 << ln_q);

    // link engine: sck divider, shifting, phase walk, chip select
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p_q     <= P_IDLE;
            div_q   <= 8'h00;
            sck_q   <= 1'b0;
            csB_q   <= 1'b1;
            ioOut_q <= 4'hC;
            ioOeB_q <= 4'h2;
            sh_q    <= 32'h0000_0000;
            rx_q    <= 32'h0000_0000;
            clk_q   <= 6'h00;
            ln_q    <= 2'h0;
            byte_q  <= 9'h000;
            done_q  <= 1'b0;
            rdat_q  <= 32'h0000_0000;
            sts_q   <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (p_q == P_IDLE) begin
                div_q <= HALF - 8'h01;
                if (go_q) begin
                    csB_q  <= 1'b0;
                    byte_q <= 9'h000;
                    p_q    <= P_OP;
                end
            end else if (!tick) begin
                div_q <= div_q - 8'h01;
            end else begin
                div_q <= HALF - 8'h01;
                if (p_q == P_END) begin
                    // cs rises with sck low, after whole phases only
                    csB_q   <= 1'b1;
                    ioOut_q <= 4'hC;
                    ioOeB_q <= 4'h2;
                    if (clk_q == 6'h00) begin
                        p_q    <= P_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        clk_q <= clk_q - 6'h01;
                    end
                end else if (!sck_q) begin
                    // rising edge: device data is settled here
                    sck_q <= 1'b1;
                    case (ln_q)
                        2'h0:    rx_q <= {rx_q[30:0], ioS[1]};
                        2'h1:    rx_q <= {rx_q[29:0], ioS[1:0]};
                        default: rx_q <= {rx_q[27:0], ioS};
                    endcase
                end else begin
                    sck_q <= 1'b0;
                    if (clk_q != 6'h01) begin
                        clk_q   <= clk_q - 6'h01;
                        sh_q    <= shNx;
                        ioOut_q <= laneOut(shNx, ln_q);
                    end else begin
                        if (p_q == P_DAT) begin
                            byte_q <= byte_q + 9'h001;
                            if (!fWr) begin
                                rdat_q <= {rdat_q[23:0], rx_q[7:0]};
                            end
                            if (seq_q == S_POLL) begin
                                sts_q <= rx_q[7:0];
                            end
                        end
                        p_q <= nxt;
                        if (nxt == P_END) begin
                            clk_q <= `SFC_CS_GAP;
                        end
                    end
                end
            end
            // a fresh phase overrides the shift above
            if (doLoad) begin
                ln_q    <= ldLn;
                sh_q    <= ldSh;
                clk_q   <= ldClk;
                ioOut_q <= laneOut(ldSh, ldLn);
                ioOeB_q <= laneOeB(ldLn, ldRd);
            end
        end
    end

    // sequencer: latch prefix, main frame, busy poll
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            seq_q   <= S_IDLE;
            start_q <= 1'b0;
            go_q    <= 1'b0;
        end else begin
            go_q    <= 1'b0;
            start_q <= 1'b0;
            case (seq_q)
                S_IDLE: begin
                    if (wrEn && (regAddr == `SFC_OFF_CMD) && !start_q) begin
                        start_q <= 1'b1;
                    end
                    if (start_q) begin
                        seq_q <= needPre ? S_PRE : S_MAIN;
                        go_q  <= 1'b1;
                    end
                end
                S_PRE: begin
                    if (done_q) begin
                        seq_q <= S_MAIN;
                        go_q  <= 1'b1;
                    end
                end
                S_MAIN: begin
                    if (done_q) begin
                        // status writes and commands with the poll bit are waited out before idle
                        seq_q <= needPoll ? S_POLL : S_IDLE;
                        go_q  <= needPoll;
                    end
                end
                default: begin
                    if (done_q) begin
                        seq_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // register writes; ignored while a command runs
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q  <= `SFC_RST_CMD;
            adr_q  <= `SFC_RST_ADDR;
            len_q  <= `SFC_RST_LEN;
            wdat_q <= `SFC_RST_WDAT;
        end else if (wrEn && !busy) begin
            if (regAddr == `SFC_OFF_CMD) begin
                cmd_q <= wrData;
            end else if (regAddr == `SFC_OFF_ADDR) begin
                adr_q <= wrData[23:0];
            end else if (regAddr == `SFC_OFF_LEN) begin
                len_q <= wrData[8:0];
            end else if (regAddr == `SFC_OFF_WDAT) begin
                wdat_q <= wrData[15:0];
            end
        end
    end

    // read decode; unmapped offsets read zero
    always @* begin
        if (regAddr == `SFC_OFF_CMD) begin
            rdData = cmd_q;
        end else if (regAddr == `SFC_OFF_ADDR) begin
            rdData = {8'h00, adr_q};
        end else if (regAddr == `SFC_OFF_LEN) begin
            rdData = {23'h00_0000, len_q};
        end else if (regAddr == `SFC_OFF_WDAT) begin
            rdData = {16'h0000, wdat_q};
        end else if (regAddr == `SFC_OFF_RDAT) begin
            rdData = rdat_q;
        end else if (regAddr == `SFC_OFF_STAT) begin
            rdData = {16'h0000, sts_q, 7'h00, busy};
        end else begin
            rdData = 32'h0000_0000;
        end
    end

    assign hresp = 1'b0;
    assign sck   = sck_q;
    assign csB   = csB_q;
    assign ioOut = ioOut_q;
    assign ioOeB = ioOeB_q;
endmodule // sfc_ctrl

// ===== src/sfc_regs.vh
// sfc_regs.vh: register map, command fields, opcodes and timing of the
// serial flash host controller; assumes 32-bit AHB-Lite byte addresses.
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
`define SFC_OFF_CMD   8'h00
`define SFC_OFF_ADDR  8'h04
`define SFC_OFF_LEN   8'h08
`define SFC_OFF_WDAT  8'h0C
`define SFC_OFF_RDAT  8'h10
`define SFC_OFF_STAT  8'h14
`define SFC_B_ALN     8
`define SFC_B_DLN     10
`define SFC_B_MODE    12
`define SFC_B_ADR     13
`define SFC_B_WR      14
`define SFC_B_QPI     15
`define SFC_B_VOL     16
`define SFC_B_POLL    17
`define SFC_B_WEL     18
`define SFC_B_DAT     19
`define SFC_B_DUM     20
`define SFC_B_MBYTE   24
`define SFC_RST_CMD   32'h0000_0000
`define SFC_RST_ADDR  24'h00_0000
`define SFC_RST_LEN   9'h001
`define SFC_RST_WDAT  16'h0000
`define SFC_LEN_MAX   9'h100
`define SFC_OP_WREN   8'h06
`define SFC_OP_VWREN  8'h50
`define SFC_OP_RDSR1  8'h05
`define SFC_OP_WRSR   8'h01
`define SFC_OP_WRSR2  8'h31
`define SFC_CS_GAP    6'h04
`endif

// ===== src/sfc_sync.v
// sfc_sync.v: two-flop synchroniser for the flash data pins.
// assumes pins are asynchronous to mclk.
module sfc_sync #(
    parameter W = 4
) (
    input  wire         mclk,
    input  wire         rst_b,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    genvar i;
    // first stage feeds only the second stage
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= din[i];
                    sync_q <= meta_q;
                end
            end
            assign dout[i] = sync_q;
        end
    endgenerate
endmodule // sfc_sync

// ===== src/sfc_ahb_slv.v
// sfc_ahb_slv.v: AHB-Lite slave front end, one wait state per transfer.
// assumes single word transfers; register storage lives in the caller.
module sfc_ahb_slv (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    input  wire [31:0] hwdata,
    input  wire [31:0] rdData,
    output wire        hreadyout,
    output wire [31:0] hrdata,
    output wire        wrEn,
    output wire [7:0]  regAddr,
    output wire [31:0] wrData
);
    reg        pend_q;
    reg        wr_q;
    reg [7:0]  adr_q;
    reg        rdy_q;
    reg [31:0] rdat_q;

    // wait state keeps hrdata straight from a flop
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
            wr_q   <= 1'b0;
            adr_q  <= 8'h00;
            rdy_q  <= 1'b1;
            rdat_q <= 32'h0000_0000;
        end else if (hsel && htrans[1] && hready) begin
            pend_q <= 1'b1;
            wr_q   <= hwrite;
            adr_q  <= haddr[7:0];
            rdy_q  <= 1'b0;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            rdy_q  <= 1'b1;
            if (!wr_q) begin
                rdat_q <= rdData;
            end
        end
    end

    assign hreadyout = rdy_q;
    assign hrdata    = rdat_q;
    assign wrEn      = pend_q & wr_q;
    assign regAddr   = adr_q;
    assign wrData    = hwdata;
endmodule // sfc_ahb_slv

// ===== dv/sfc_ctrl_asserts.sv
// sfc_ctrl_asserts.sv: port checker for the flash host controller.
// assumes a mode 0 flash link and a single AHB-Lite master.
module sfc_ctrl_asserts #(
    parameter int HALF = 4
) (
    input wire       mclk,
    input wire       rst_b,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hready,
    input wire       hreadyout,
    input wire       hresp,
    input wire       sck,
    input wire       csB,
    input wire [3:0] ioOut,
    input wire [3:0] ioOeB
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // bus: every taken transfer gets exactly one wait state
    sequence s_take; hsel && htrans[1] && hready; endsequence
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    property p_wait; s_take |=> s_wait; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");

    // link framing: clock parked low outside a frame
    property p_idle; csB |-> !sck; endproperty
    a_idle: assert property (p_idle) else $error("sck high while deselected");
    property p_csedge; $changed(csB) |-> !sck && !$past(sck); endproperty
    a_csedge: assert property (p_csedge) else $error("select moved near sck high");
    property p_first; $fell(csB) |-> ##HALF $rose(sck); endproperty
    a_first: assert property (p_first) else $error("first sck rise late");
    property p_half; $rose(sck) |-> ##HALF $fell(sck); endproperty
    a_half: assert property (p_half) else $error("sck high half wrong");
    // the device samples on rise, so lanes must hold while sck is high
    property p_iostab; !csB && sck |-> $stable(ioOut) && $stable(ioOeB); endproperty
    a_iostab: assert property (p_iostab) else $error("lane moved with sck high");
    property p_gap; $rose(csB) |=> csB [*8]; endproperty
    a_gap: assert property (p_gap) else $error("frames too close");
endmodule // sfc_ctrl_asserts

bind sfc_ctrl sfc_ctrl_asserts #(.HALF(HALF)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .sck(sck), .csB(csB), .ioOut(ioOut),
    .ioOeB(ioOeB));

// ===== dv/sfc_flash_model.sv
// sfc_flash_model.sv: behavioural single-lane serial flash.
// assumes a mode 0 host; io0, io2 and io3 carry pull-ups.
module sfc_flash_model #(
    parameter int TW = 2000 // self-timed write, ns
) (
    input  wire       csB,
    input  wire       sck,
    input  wire [3:0] ioOut,
    input  wire [3:0] ioOeB,
    output wire [3:0] ioIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        write_enable_latch = 1'b0, busy = 1'b0, volArm = 1'b0, drv = 1'b0, so = 1'b0;
    logic [7:0]  srLo = 8'h00, srHi = 8'h00, op = 8'h00, sh, b1, tx;
    logic [23:0] addr;
    int          cnt, st;
    wire  [7:0]  stat1 = {srLo[7:2], write_enable_latch, busy};

    // released io1 shows the inverse of its last bit, not a stale copy
    assign ioIn[0] = ioOeB[0] ? 1'b1 : ioOut[0];
    assign ioIn[1] = drv ? so : (ioOeB[1] ? ~so : ioOut[1]);
    assign ioIn[2] = ioOeB[2] ? 1'b1 : ioOut[2];
    assign ioIn[3] = ioOeB[3] ? 1'b1 : ioOut[3];

    // output start bit; array reads never start while busy
    always_comb st = (op == 8'h05 || op == 8'h35) ? 8 : busy ? 0 :
                     (op == 8'h03) ? 32 : (op == 8'h0B) ? 40 : 0;

    always @(negedge csB) cnt = 0;

    // capture opcode, address and first data byte on rise
    always @(posedge sck) if (!csB) begin
        sh = {sh[6:0], ioIn[0]};
        cnt++;
        if (cnt == 8) op = sh;
        if (cnt > 8 && cnt <= 32) addr = {addr[22:0], ioIn[0]};
        if (cnt == 16) b1 = sh;
    end

    // shift out on fall, reloading a byte every eight bits
    always @(negedge sck) if (!csB && st > 0 && cnt >= st) begin
        if ((cnt - st) % 8 == 0) begin
            tx = (op == 8'h05) ? stat1 : (op == 8'h35) ? srHi : addr[7:0] ^ 8'h5A;
            if (st > 8) addr++;
        end
        so = tx[7 - (cnt - st) % 8];
        drv = 1'b1;
    end

    // frame end: latch commands and status writes act only here
    always @(posedge csB) begin
        drv = 1'b0;
        if (cnt == 8 && op == 8'h06) write_enable_latch = 1'b1;
        if (cnt == 8 && op == 8'h04) write_enable_latch = 1'b0;
        if ((op == 8'h01 && (cnt == 16 || cnt == 24) || op == 8'h31 && cnt == 16)
            && (write_enable_latch || volArm) && !busy) begin
            if (op == 8'h01) srLo = srLo & 8'h03 | b1 & 8'hFC;
            if (op == 8'h31) srHi = srHi & 8'hBC | b1 & 8'h43;
            else srHi = srHi & 8'hBC | (cnt == 24 ? sh & 8'h43 : 8'h00);
            if (!volArm) begin
                write_enable_latch = 1'b0;
                busy = 1'b1;
                busy <= #(TW) 1'b0;
            end
        end
        volArm = cnt == 8 && op == 8'h50;
    end
endmodule // sfc_flash_model

// ===== dv/sfc_ctrl_test.sv
// sfc_ctrl_test.sv: bench driving the flash controller over AHB-Lite.
// assumes the flash model and the bound checker are compiled first.
module sfc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'b00;
    wire         hreadyout, hresp, sck, csB;
    wire  [31:0] hrdata;
    wire  [3:0]  ioOut, ioOeB, ioIn;
    int          bad_count = 0, total_checks = 0, cyc = 0;

    sfc_ctrl #(.HALF(8'h04)) dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck(sck), .csB(csB),
        .ioOut(ioOut), .ioOeB(ioOeB), .ioIn(ioIn));
    sfc_flash_model fm (.csB(csB), .sck(sck), .ioOut(ioOut), .ioOeB(ioOeB), .ioIn(ioIn));

    always #4 mclk = ~mclk;

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end

    task results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // load a command; a length write while busy must be dropped
    task automatic run(input logic [31:0] c, a, n, w);
        ahb(1'b1, 8'h04, a);
        ahb(1'b1, 8'h08, n);
        ahb(1'b1, 8'h0C, w);
        ahb(1'b1, 8'h00, c);
        repeat (4) @(posedge mclk);
        ahb(1'b1, 8'h08, 32'h77);
        do ahb(1'b0, 8'h14, 32'h0); while (rd[0] !== 1'b0);
    endtask

    // four bytes of the repeating status byte fill the whole read word
    task automatic st(input logic [7:0] o, e);
        run({24'h0008_00, o}, 32'h0, 32'h4, 32'h0);
        chkRd(8'h10, {4{e}});
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chkRd(8'h08, 32'h1);
        chkRd(8'h00, 32'h0);
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chkRd(8'h20, 32'h0);
        st(8'h05, 8'h00);
        run(32'h6, 32'h0, 32'h1, 32'h0);
        st(8'h05, 8'h02);
        run(32'h4, 32'h0, 32'h1, 32'h0);
        st(8'h05, 8'h00);
        run(32'h0008_4001, 32'h0, 32'h2, 32'hFFFF);
        chkRd(8'h14, 32'h0000_FC00);
        st(8'h05, 8'hFC);
        st(8'h35, 8'h43);
        run(32'h0008_4031, 32'h0, 32'h1, 32'hBE);
        st(8'h35, 8'h02);
        st(8'h05, 8'hFC);
        run(32'h0008_4001, 32'h0, 32'h1, 32'h10);
        st(8'h05, 8'h10);
        st(8'h35, 8'h00);
        run(32'h0009_4001, 32'h0, 32'h2, 32'h4324);
        st(8'h05, 8'h24);
        st(8'h35, 8'h43);
        run(32'h0008_0005, 32'h0, 32'h4, 32'h0);
        chkRd(8'h10, 32'h2424_2424);
        run(32'h0008_2003, 32'h10, 32'h4, 32'h0);
        chkRd(8'h10, 32'h4A4B_4849);
        run(32'h0088_200B, 32'hFE, 32'h4, 32'h0);
        chkRd(8'h10, 32'hA4A5_5A5B);
        chkRd(8'h08, 32'h4);
        results();
    end
endmodule // sfc_ctrl_test
